// ==== include/rst_irq_defines.vh ====
`ifndef RST_IRQ_DEFINES_VH
`define RST_IRQ_DEFINES_VH

// Malfunction reset hold, in fast clock periods; core_clk is the fast clock
`define MAL_RST_FC_PERIODS    24
`define CORE_CLK_PER_FC       1
// Product of the two above, sized to the stretch counter width
`define MAL_RST_CYCLES        5'h18
`define MAL_CNT_W             5

// Least low time of the reset pin, kept by the party driving it
`define EXT_RST_MIN_FC        12

// Vector addresses
`define VEC_RESET             16'hfffe
`define VEC_NO_LATCH          16'hfffc
`define VEC_TRAP              16'hfffa
`define VEC_WDT               16'hfff8
`define VEC_LOW_BASE          16'hfff6
`define VEC_HIGH_BASE         16'hffbe

// Source slots
`define SLOT_W                5
`define SLOT_NO_LATCH         5'h00
`define SLOT_TRAP             5'h02
`define SLOT_WDT              5'h03
`define SLOT_MASK_FIRST       5'h04
`define SLOT_HIGH_FIRST       5'h10
`define BIT_TRAP              2
`define BIT_WDT               3
`define BIT_EXT0              6
`define NUM_SLOTS             32

// Slot masks
`define SRC_PRESENT_MASK      32'h18fe6fd0
`define NMI_LATCH_MASK        32'h0000000c
`define MASKABLE_MASK         32'hfffffff0
`define LATCH_CLEAR           32'h00000000

// Clock select encodings
`define CLK_SEL_FAST          1'b0
`define CLK_SEL_SLOW          1'b1

// Action select values
`define ACTION_RESET          1'b1

`endif

// ==== verif/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       core_clk,
  input  wire logic       serve,
  input  wire logic [1:0] delay,
  input  wire logic       irq_request,
  input  wire logic       imf_stacked,
  output logic            irq_ack,
  output logic            reti,
  output logic            reti_imf
);
  logic [1:0] cnt_r;
  logic       busy_r;
  initial {irq_ack, reti, reti_imf, cnt_r, busy_r} = 6'h0;
  always @(negedge core_clk)
  begin
    irq_ack <= 1'b0;
    reti <= 1'b0;
    // Qualifier is wrong whenever no return is issued
    reti_imf <= ~imf_stacked;
    cnt_r <= 2'h0;
    if (busy_r || (serve && irq_request && !irq_ack))
    begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == delay)
      begin
        cnt_r <= 2'h0;
        busy_r <= !busy_r;
        irq_ack <= !busy_r;
        reti <= busy_r;
        if (busy_r)
          reti_imf <= imf_stacked;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/reset_and_interrupt_vectoring_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rst_irq_checker (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        core_reset,
  input wire logic        reset_vector_fetch,
  input wire logic        prescaler_clear,
  input wire logic        watchdog_force_enable,
  input wire logic        osc_write_block,
  input wire logic        trap_action_select,
  input wire logic        watchdog_action_select,
  input wire logic        ext_irq_zero_gate,
  input wire logic        global_irq_enable,
  input wire logic        imf_stacked,
  input wire logic        irq_request,
  input wire logic        irq_ack,
  input wire logic [15:0] reset_vector_addr,
  input wire logic [15:0] irq_vector,
  input wire logic [31:0] request_latches,
  input wire logic [31:0] source_enable_bits,
  input wire logic [4:0]  irq_slot
);
  logic [7:0] run_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Saturates so a stuck reset cannot wrap back under the bound
  always @(posedge core_clk)
    if (reset || !core_reset)
      run_r <= 8'h00;
    else if (run_r != 8'hff)
      run_r <= run_r + 8'h01;
  AST_RST_CLEAR: assert property (
    $past(core_reset) && core_reset |-> request_latches == 32'h0 && !global_irq_enable
      && source_enable_bits == 32'h0 && trap_action_select && watchdog_action_select)
    else $error("Reset left interrupt state set");
  AST_TIMEGEN: assert property (
    $past(core_reset) && core_reset |-> prescaler_clear && watchdog_force_enable)
    else $error("Timing clear or watchdog enable missing in reset");
  AST_VEC_FETCH: assert property (
    $fell(core_reset) |-> reset_vector_fetch && reset_vector_addr == 16'hfffe)
    else $error("No reset vector fetch at release");
  AST_MAL_HOLD: assert property (core_reset |-> run_r < 8'h19)
    else $error("Internal reset held too long");
  AST_OSC_RST: assert property (osc_write_block |-> ##2 core_reset [*4])
    else $error("Clock stall write gave no reset");
  AST_GATE: assert property (
    irq_request && irq_slot >= 5'h04 |-> global_irq_enable && request_latches[irq_slot]
      && source_enable_bits[irq_slot] && (irq_slot != 5'h06 || ext_irq_zero_gate))
    else $error("Maskable request presented while disabled");
  AST_VEC: assert property (
    irq_request |-> irq_vector == (irq_slot == 5'h00 ? 16'hfffc : irq_slot < 5'h10 ?
      16'hfffe - {irq_slot, 1'b0} : 16'hffde - {irq_slot, 1'b0}))
    else $error("Wrong vector for presented slot");
  AST_NMI_FIRST: assert property (
    (request_latches[2] || request_latches[3]) && !core_reset |-> irq_request
      && irq_slot < 5'h04)
    else $error("Non-maskable latch not served first");
  AST_PRIO: assert property (
    irq_request && irq_slot >= 5'h04 |-> (request_latches & source_enable_bits
      & ((32'h1 << irq_slot) - 32'h1) & 32'hfffffff0
      & ~(ext_irq_zero_gate ? 32'h0 : 32'h40)) == 32'h0)
    else $error("Higher priority enabled source skipped");
  AST_ACK: assert property (
    irq_ack && irq_request |=> !global_irq_enable && imf_stacked == $past(global_irq_enable))
    else $error("Accept did not stack and clear master enable");
endmodule
bind reset_and_interrupt_vectoring rst_irq_checker chk (.*);
`default_nettype wire

// ==== verif/reset_and_interrupt_vectoring_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rst_irq_defines.vh"
module reset_and_interrupt_vectoring_tb_top;
  logic core_clk, reset, reset_pin_n, fetch_valid, trap_ram_area_select, software_irq;
  logic watchdog_control_one_wr, trap_action_wdata, watchdog_action_wdata, latch_wr;
  logic watchdog_overflow, system_control_two_wr, fast_osc_en_wdata, slow_osc_en_wdata;
  logic clk_select, undefined_opcode_irq, ext_irq_zero_gate, enable_wr, imf_wr, imf_wdata;
  logic irq_ack, reti, reti_imf, core_reset, reset_vector_fetch, prescaler_clear;
  logic watchdog_force_enable, osc_write_block, trap_action_select, watchdog_action_select;
  logic global_irq_enable, imf_stacked, irq_request, serve, im, gt;
  logic [1:0] delay;
  logic [4:0] irq_slot;
  logic [15:0] fetch_addr, reset_vector_addr, irq_vector;
  logic [31:0] irq_src, latch_wdata, enable_wdata, request_latches, source_enable_bits;
  logic [31:0] en, pend;
  logic [17:0] tt [7];
  int bad_count, compares, k, n, b;
  reset_and_interrupt_vectoring uut (.*);
  core_model cpu (.*);
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  task cyc;
    @(negedge core_clk);
    #1;
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task wrap_up;
    $display("Checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // w: 0 accept, 1 return, 2 reset high, 3 reset low
  task wt(input int w, input int lim);
    k = 0;
    while (!(w == 0 ? irq_ack === 1'b1 : w == 1 ? reti === 1'b1 : core_reset === (w == 2))
           && k < lim)
    begin
      cyc;
      k++;
    end
    if (k >= lim)
    begin
      $display("Error wait %0d expected done seen timeout", w);
      bad_count++;
      wrap_up;
    end
  endtask
  task mrst(input string nm, input int mx);
    wt(2, 8);
    wt(3, 100);
    chk({nm, " hold"}, 1, k <= mx);
    chk({nm, " fetch"}, 1, reset_vector_fetch);
    chk({nm, " clear"}, 64'h0, {request_latches, source_enable_bits});
    chk({nm, " flags"}, 3'b011, {global_irq_enable, trap_action_select,
        watchdog_action_select});
  endtask
  task lclr;
    latch_wr = 1'b1;
    latch_wdata = 32'h0;
    cyc;
    latch_wr = 1'b0;
    latch_wdata = $urandom;
  endtask
  function automatic logic [15:0] vec(input int s);
    return s < 16 ? 16'hfffe - 16'(2 * s) : 16'hffde - 16'(2 * s);
  endfunction
  function automatic int best(input logic [31:0] p);
    best = -1;
    for (int s = 31; s >= 4; s--)
      if (p[s] && en[s] && im && (s != 6 || gt))
        best = s;
  endfunction
  initial
  begin
    {reset, fetch_valid, trap_ram_area_select, watchdog_control_one_wr, trap_action_wdata,
     watchdog_action_wdata, watchdog_overflow, system_control_two_wr, software_irq,
     undefined_opcode_irq, ext_irq_zero_gate, latch_wr, enable_wr, imf_wr, imf_wdata,
     serve} = 16'h8000;
    {reset_pin_n, fast_osc_en_wdata, slow_osc_en_wdata, clk_select} = 4'he;
    {fetch_addr, irq_src, latch_wdata, enable_wdata, delay} = '0;
    {bad_count, compares, n} = '0;
    void'($urandom(32'h9f70c406));
    repeat (16) cyc;
    reset = 1'b0;
    mrst("power up", 26);
    tt = '{{16'h0010, 2'b01}, {16'h0100, 2'b00}, {16'h0100, 2'b11}, {16'h0f80, 2'b01},
           {16'h1000, 2'b10}, {16'h023f, 2'b11}, {16'h0240, 2'b10}};
    repeat (24)
    begin
      lclr;
      {en, pend, im, gt, delay} = {$urandom, $urandom, 4'($urandom)};
      if (n == 0)
        {en, pend, im, gt} = {32'hffffffff, 32'h10000040, 2'b10};
      {enable_wr, enable_wdata, imf_wr, imf_wdata, ext_irq_zero_gate} = {1'b1, en, 1'b1, im, gt};
      cyc;
      {enable_wr, imf_wr, irq_src} = {2'b00, pend};
      cyc;
      irq_src = 32'h0;
      pend = pend & `SRC_PRESENT_MASK;
      b = best(pend);
      chk("latches", pend, request_latches);
      chk("enables", en & 32'hfffffff0, source_enable_bits);
      chk("request", b >= 0, irq_request);
      if (b >= 0)
      begin
        chk("slot vector", {b[4:0], vec(b)}, {irq_slot, irq_vector});
        serve = 1'b1;
        wt(0, 10);
        serve = 1'b0;
        cyc;
        chk("accept", {pend & ~(32'h1 << b), 1'b0, im},
            {request_latches, global_irq_enable, imf_stacked});
        wt(1, 10);
        cyc;
        chk("return", im, global_irq_enable);
      end
      n++;
    end
    for (int i = 0; i < 2; i++)
    begin
      {software_irq, undefined_opcode_irq} = i ? 2'b01 : 2'b10;
      cyc;
      chk("no latch nmi", {6'h20, 16'hfffc}, {irq_request, irq_slot, irq_vector});
    end
    {software_irq, undefined_opcode_irq, watchdog_control_one_wr} = 3'b001;
    {trap_action_wdata, watchdog_action_wdata} = 2'b00;
    cyc;
    watchdog_control_one_wr = 1'b0;
    foreach (tt[i])
    begin
      lclr;
      {fetch_addr, trap_ram_area_select, fetch_valid} = {tt[i][17:1], 1'b1};
      cyc;
      {fetch_valid, fetch_addr} = {1'b0, ~fetch_addr};
      chk("trap latch", tt[i][0], request_latches[2]);
    end
    {fetch_valid, fetch_addr, watchdog_overflow} = {1'b1, 16'h0f00, 1'b1};
    cyc;
    {fetch_valid, watchdog_overflow} = 2'b00;
    chk("nmi pair", {7'h62, 16'hfffa}, {request_latches[3:2], irq_slot, irq_vector});
    serve = 1'b1;
    wt(0, 10);
    serve = 1'b0;
    cyc;
    chk("wdt next", {7'h43, 16'hfff8}, {request_latches[3:2], irq_slot, irq_vector});
    wt(1, 10);
    {watchdog_control_one_wr, trap_action_wdata, watchdog_action_wdata} = 3'b111;
    cyc;
    {watchdog_control_one_wr, watchdog_overflow} = 2'b01;
    cyc;
    watchdog_overflow = 1'b0;
    mrst("watchdog", 24);
    {fetch_valid, fetch_addr} = {1'b1, 16'h0020};
    cyc;
    fetch_valid = 1'b0;
    mrst("trap", 24);
    for (int c = 0; c < 8; c++)
    begin
      {fast_osc_en_wdata, slow_osc_en_wdata, clk_select, system_control_two_wr} = 4'(2 * c + 1);
      #1;
      b = (!c[2] && (!c[1] || !c[0])) || (!c[1] && c[0]);
      chk("osc block", b, osc_write_block);
      cyc;
      {system_control_two_wr, fast_osc_en_wdata, slow_osc_en_wdata} = 3'b011;
      if (b)
        mrst("clock", 24);
      else
      begin
        cyc;
        chk("no clock reset", 0, core_reset);
      end
    end
    reset_pin_n = 1'b0;
    repeat (12) cyc;
    reset_pin_n = 1'b1;
    mrst("pin", 20);
    reset = 1'b1;
    repeat (3) cyc;
    reset = 1'b0;
    mrst("second", 26);
    wrap_up;
  end
endmodule
`default_nettype wire

// ==== verilog/irq_arbiter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rst_irq_defines.vh"

module irq_arbiter
(
  input  wire [`NUM_SLOTS-1:0] pending,
  input  wire                  no_latch_req,
  output reg                   req,
  output reg  [`SLOT_W-1:0]    slot,
  output wire [15:0]           vector
);

  integer i;

  function [15:0] vec_of;
    input [`SLOT_W-1:0] s;
    reg   [`SLOT_W-1:0] off;
    begin
      off = `SLOT_W'h00;
      if (s == `SLOT_NO_LATCH)
        vec_of = `VEC_NO_LATCH;
      else if (s == `SLOT_TRAP)
        vec_of = `VEC_TRAP;
      else if (s == `SLOT_WDT)
        vec_of = `VEC_WDT;
      else if (s < `SLOT_HIGH_FIRST)
      begin
        off = s - `SLOT_MASK_FIRST;
        vec_of = `VEC_LOW_BASE - {10'h000, off, 1'b0};
      end
      else
      begin
        off = s - `SLOT_HIGH_FIRST;
        vec_of = `VEC_HIGH_BASE - {10'h000, off, 1'b0};
      end
    end
  endfunction

  // Scan downward so the lowest slot number, the highest priority, is left
  always @*
  begin
    req  = 1'b0;
    slot = `SLOT_NO_LATCH;
    for (i = `NUM_SLOTS - 1; i >= `SLOT_MASK_FIRST; i = i - 1)
    begin
      if (pending[i])
      begin
        req  = 1'b1; // RQ16
        slot = i[`SLOT_W-1:0];
      end
    end
    // Non-maskables share one level; a fixed pick is still needed for one vector
    if (pending[`BIT_WDT])
    begin
      req  = 1'b1; // RQ17
      slot = `SLOT_WDT;
    end
    if (pending[`BIT_TRAP])
    begin
      req  = 1'b1; // RQ17
      slot = `SLOT_TRAP;
    end
    if (no_latch_req)
    begin
      req  = 1'b1; // RQ17
      slot = `SLOT_NO_LATCH;
    end
  end

  assign vector = vec_of(slot); // RQ18 RQ19 RQ23

endmodule
`default_nettype wire

// ==== verilog/mal_reset_stretch.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rst_irq_defines.vh"

module mal_reset_stretch
#(
  parameter [`MAL_CNT_W-1:0] HOLD_CYCLES = `MAL_RST_CYCLES
)
(
  input  wire core_clk,
  input  wire reset,
  input  wire trigger,
  output wire hold
);

  reg [`MAL_CNT_W-1:0] cnt_r;

  // Power-up loads a full count: the spurious reset the core sees at power-on
  always @(posedge core_clk)
  begin
    if (reset)
      cnt_r <= HOLD_CYCLES; // RQ3
    else if (trigger)
      cnt_r <= HOLD_CYCLES; // RQ2
    else if (cnt_r != {`MAL_CNT_W{1'b0}})
      cnt_r <= cnt_r - {{(`MAL_CNT_W-1){1'b0}}, 1'b1};
  end

  assign hold = (cnt_r != {`MAL_CNT_W{1'b0}}); // RQ2

endmodule
`default_nettype wire

// ==== verilog/reset_and_interrupt_vectoring.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rst_irq_defines.vh"

// Contract
// [RQ1] Reset from pin, address trap, watchdog, clock shutdown; last three are malfunction.
// [RQ2] Malfunction reset request holds internal reset at most 24 fast clocks.
// [RQ3] Malfunction logic not cleared by power-up; up to 24-clock spurious reset.
// [RQ4] Any reset clears master enable, individual enables and request latches.
// [RQ5] Reset clears timing generator prescaler and divider, leaves watchdog enabled.
// [RQ6] Reset leaves stack pointer, registers, flags and RAM untouched.
// [RQ7] External party holds reset pin low at least twelve fast clocks.
// [RQ8] On release the core loads the PC from the top-of-memory reset vector.
// [RQ9] Fetch from special area or data buffer traps; RAM too when selected.
// [RQ10] Address trap gives reset or non-maskable interrupt by selection.
// [RQ11] Trap and watchdog actions default to reset; interrupt only when cleared.
// [RQ12] Oscillator shutdown writes that would stall the clock cause reset.
// [RQ13] Twenty-two sources besides reset; four non-maskable, rest maskable.
// [RQ14] Each latched source has its own latch set on request and vector.
// [RQ15] Maskable source accepted only with master and its own enable set.
// [RQ16] Fixed priority: reset, non-maskables, then slots 4 to 31 in order.
// [RQ17] The four non-maskables share one priority level.
// [RQ18] Software and undefined-opcode share FFFC, trap FFFA, watchdog FFF8.
// [RQ19] Slot n uses latch n, enable n; vectors descend by two per slot. The code steps from FFE0 at slot 15 to FFBE at slot 16.
// [RQ20] External interrupt zero also needs its pin-function gate set.
// [RQ21] Acceptance clears its latch, stacks and clears master enable; return restores.
// [RQ22] Reserved slots keep positions but are never requested by hardware.
// [RQ23] Vector of the best pending request is presented in the same cycle.
module reset_and_interrupt_vectoring
#(
  parameter [15:0] SFR_FIRST = 16'h0000,
  parameter [15:0] SFR_LAST  = 16'h003f,
  parameter [15:0] RAM_FIRST = 16'h0040,
  parameter [15:0] RAM_LAST  = 16'h023f,
  parameter [15:0] DBR_FIRST = 16'h0f00,
  parameter [15:0] DBR_LAST  = 16'h0fff
)
(
  input  wire                  core_clk,
  input  wire                  reset,
  input  wire                  reset_pin_n,
  input  wire                  fetch_valid,
  input  wire [15:0]           fetch_addr,
  input  wire                  trap_ram_area_select,
  input  wire                  watchdog_control_one_wr,
  input  wire                  trap_action_wdata,
  input  wire                  watchdog_action_wdata,
  input  wire                  watchdog_overflow,
  input  wire                  system_control_two_wr,
  input  wire                  fast_osc_en_wdata,
  input  wire                  slow_osc_en_wdata,
  input  wire                  clk_select,
  input  wire [`NUM_SLOTS-1:0] irq_src,
  input  wire                  software_irq,
  input  wire                  undefined_opcode_irq,
  input  wire                  ext_irq_zero_gate,
  input  wire                  latch_wr,
  input  wire [`NUM_SLOTS-1:0] latch_wdata,
  input  wire                  enable_wr,
  input  wire [`NUM_SLOTS-1:0] enable_wdata,
  input  wire                  imf_wr,
  input  wire                  imf_wdata,
  input  wire                  irq_ack,
  input  wire                  reti,
  input  wire                  reti_imf,
  output wire                  core_reset,
  output wire                  reset_vector_fetch,
  output wire [15:0]           reset_vector_addr,
  output wire                  prescaler_clear,
  output wire                  watchdog_force_enable,
  output wire                  osc_write_block,
  output wire                  trap_action_select,
  output wire                  watchdog_action_select,
  output wire [`NUM_SLOTS-1:0] request_latches,
  output wire [`NUM_SLOTS-1:0] source_enable_bits,
  output wire                  global_irq_enable,
  output wire                  imf_stacked,
  output wire                  irq_request,
  output wire [`SLOT_W-1:0]    irq_slot,
  output wire [15:0]           irq_vector
);

  // Inclusive bounds; the areas are parameters so a smaller map can reuse this
  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // One-hot mask of a source slot
  function [`NUM_SLOTS-1:0] slot_bit;
    input [`SLOT_W-1:0] s;
    begin
      slot_bit = {{(`NUM_SLOTS-1){1'b0}}, 1'b1} << s;
    end
  endfunction

  reg                  pin_meta_r;
  reg                  pin_sync_r;
  reg                  core_reset_r;
  reg                  rst_fetch_r;
  reg                  trap_action_r;
  reg                  wdt_action_r;
  reg [`NUM_SLOTS-1:0] latch_r;
  reg [`NUM_SLOTS-1:0] latch_nxt;
  reg [`NUM_SLOTS-1:0] enable_r;
  reg                  imf_r;
  reg                  imf_nxt;
  reg                  imf_stack_r;

  wire                  pin_low;
  wire                  mal_hold;
  wire                  int_rst;
  wire                  trap_area;
  wire                  trap_hit;
  wire                  trap_rst_req;
  wire                  trap_irq_set;
  wire                  wdt_rst_req;
  wire                  wdt_irq_set;
  wire                  clk_rst_req;
  wire                  mal_trigger;
  wire [`NUM_SLOTS-1:0] set_vec;
  wire [`NUM_SLOTS-1:0] sw_clr;
  wire [`NUM_SLOTS-1:0] ack_clr;
  wire [`NUM_SLOTS-1:0] accept_mask;
  wire [`NUM_SLOTS-1:0] pending;
  wire                  no_latch_req;
  wire                  arb_req;
  wire [`SLOT_W-1:0]    arb_slot;
  wire                  take;

  // Reset pin is asynchronous to core_clk
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end
    else
    begin
      pin_meta_r <= reset_pin_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pin low time is not measured; a driver obeying the minimum width is assumed
  assign pin_low = ~pin_sync_r; // RQ1 RQ7

  // Address trap: fetch into register, buffer or optionally RAM space
  assign trap_area = in_range(fetch_addr, SFR_FIRST, SFR_LAST) |
                     in_range(fetch_addr, DBR_FIRST, DBR_LAST) |
                     (trap_ram_area_select & in_range(fetch_addr, RAM_FIRST, RAM_LAST)); // RQ9
  assign trap_hit     = fetch_valid & ~core_reset_r & trap_area; // RQ9
  assign trap_rst_req = trap_hit & (trap_action_r == `ACTION_RESET); // RQ10
  assign trap_irq_set = trap_hit & (trap_action_r != `ACTION_RESET); // RQ10

  assign wdt_rst_req = watchdog_overflow & (wdt_action_r == `ACTION_RESET); // RQ11
  assign wdt_irq_set = watchdog_overflow & (wdt_action_r != `ACTION_RESET); // RQ11

  // A write that would stop the clock feeding the core is refused and resets
  assign clk_rst_req = system_control_two_wr &
                       ((~fast_osc_en_wdata & ~slow_osc_en_wdata) |
                        (~fast_osc_en_wdata & (clk_select == `CLK_SEL_FAST)) |
                        (~slow_osc_en_wdata & (clk_select == `CLK_SEL_SLOW))); // RQ12
  // The refused write never reaches the oscillators, so both keep running
  assign osc_write_block = clk_rst_req; // RQ12

  assign mal_trigger = trap_rst_req | wdt_rst_req | clk_rst_req; // RQ1

  // One stretcher for all malfunction sources; a new trigger restarts the count
  mal_reset_stretch
  #(
    .HOLD_CYCLES (`MAL_RST_CYCLES)
  )
  u_stretch
  (
    .core_clk (core_clk),
    .reset    (reset),
    .trigger  (mal_trigger),
    .hold     (mal_hold)
  );

  assign int_rst = reset | pin_low | mal_hold; // RQ1

  // Only the reset-related state lives here; core registers and RAM see no reset
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      core_reset_r <= 1'b1;
      rst_fetch_r  <= 1'b0;
    end
    else
    begin
      core_reset_r <= int_rst; // RQ6
      rst_fetch_r  <= core_reset_r & ~int_rst; // RQ8
    end
  end

  assign core_reset            = core_reset_r;
  assign reset_vector_fetch    = rst_fetch_r; // RQ8
  assign reset_vector_addr     = `VEC_RESET; // RQ8
  assign prescaler_clear       = core_reset_r; // RQ5
  assign watchdog_force_enable = core_reset_r; // RQ5

  // Action selects
  // Both return to reset request whenever the internal reset is active
  always @(posedge core_clk)
  begin
    if (int_rst)
    begin
      trap_action_r <= `ACTION_RESET; // RQ11
      wdt_action_r  <= `ACTION_RESET; // RQ11
    end
    else if (watchdog_control_one_wr)
    begin
      trap_action_r <= trap_action_wdata; // RQ10
      wdt_action_r  <= watchdog_action_wdata;
    end
  end

  assign trap_action_select     = trap_action_r;
  assign watchdog_action_select = wdt_action_r;

  // Interrupt acceptance
  assign no_latch_req = software_irq | undefined_opcode_irq; // RQ18
  // Acceptance is refused during internal reset so no latch is cleared unseen
  assign take         = irq_ack & arb_req & ~core_reset_r;

  // Latch bits 0 and 1 do not exist; software and undefined-opcode are unlatched
  assign set_vec = (irq_src & `SRC_PRESENT_MASK) |
                   ({`NUM_SLOTS{trap_irq_set}} & slot_bit(`SLOT_TRAP)) |
                   ({`NUM_SLOTS{wdt_irq_set}} & slot_bit(`SLOT_WDT)); // RQ14 RQ22
  assign sw_clr  = latch_wr ? ~latch_wdata : `LATCH_CLEAR;
  assign ack_clr = (take && (arb_slot != `SLOT_NO_LATCH)) ? slot_bit(arb_slot) : `LATCH_CLEAR; // RQ21

  // A new request beats a software or acceptance clear in the same cycle
  always @*
  begin
    latch_nxt = ((latch_r & ~sw_clr & ~ack_clr) | set_vec) &
                (`SRC_PRESENT_MASK | `NMI_LATCH_MASK); // RQ14
  end

  // Acceptance outranks a return, which outranks a plain write, when they meet
  always @*
  begin
    imf_nxt = imf_r;
    if (take)
      imf_nxt = 1'b0; // RQ21
    else if (reti)
      imf_nxt = reti_imf; // RQ21
    else if (imf_wr)
      imf_nxt = imf_wdata;
  end

  always @(posedge core_clk)
  begin
    if (int_rst)
    begin
      latch_r     <= `LATCH_CLEAR; // RQ4
      enable_r    <= `LATCH_CLEAR; // RQ4
      imf_r       <= 1'b0; // RQ4
      imf_stack_r <= 1'b0;
    end
    else
    begin
      latch_r <= latch_nxt;
      imf_r   <= imf_nxt;
      if (enable_wr)
        enable_r <= enable_wdata & `MASKABLE_MASK; // RQ19
      if (take)
        imf_stack_r <= imf_r; // RQ21
    end
  end

  // Non-maskable latches bypass the master enable; slot 6 also needs its pin gate
  assign accept_mask = `NMI_LATCH_MASK |
                       ({`NUM_SLOTS{imf_r}} & enable_r & `MASKABLE_MASK &
                        ~({`NUM_SLOTS{~ext_irq_zero_gate}} & slot_bit(`BIT_EXT0))); // RQ13 RQ15 RQ20
  assign pending     = latch_r & accept_mask; // RQ15

  irq_arbiter u_arb
  (
    .pending      (pending),
    .no_latch_req (no_latch_req),
    .req          (arb_req),
    .slot         (arb_slot),
    .vector       (irq_vector)
  );

  // The arbiter itself is ungated; requests are hidden while the core is in reset
  assign irq_request        = arb_req & ~core_reset_r; // RQ16 RQ23
  assign irq_slot           = arb_slot;
  assign request_latches    = latch_r;
  assign source_enable_bits = enable_r;
  assign global_irq_enable  = imf_r;
  assign imf_stacked        = imf_stack_r;

endmodule
`default_nettype wire
